// ### design/ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
// register byte offsets on the bus
`define CCR_OFS_STATUS 12'h000
`define CCR_OFS_CMP1 12'h004
`define CCR_OFS_CMP2 12'h008
`define CCR_OFS_VREF 12'h00C
`define CCR_OFS_IRQ_STAT 12'h010
`define CCR_OFS_IRQ_MASK 12'h014
`define CCR_OFS_SLEEP 12'h018
// field positions
`define CCR_BIT_WAKE_FLAG 6
`define CCR_BIT_RESULT 7
`define CCR_BIT_ON 3
`define CCR_BIT_NEG_SEL 2
`define CCR_BIT_WAKE_DIS 0
`define CCR_BIT_REF_POWER 7
`define CCR_BIT_REF_PIN 6
`define CCR_BIT_REF_RANGE 5
`define CCR_BIT_REF_UNUSED 4
// reset values
`define CCR_RST_CMP 8'hFF
`define CCR_RST_VREF 8'h00
// writable masks
`define CCR_WMASK_CMP 8'h7F
`define CCR_WMASK_VREF 8'hEF
// interrupt bits: 0 wake flag, 1 comparator one change, 2 comparator two change
`define CCR_IRQ_BITS 3
`endif

// ### design/ccr_pkg.sv
package ccr_pkg;
   // bus response codes
   typedef enum logic [1:0] {CCR_RESP_OKAY = 2'h0, CCR_RESP_SLVERR = 2'h2} ccr_resp_type;
   // reference ladder tap: range and level
   typedef struct packed {
      logic low_range;
      logic [3:0] level;
   } ccr_tap_type;
endpackage : ccr_pkg

// ### design/ccr_regs.sv
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ccr_map.svh"
// What this block does
// R1: an enabled comparator keeps running in sleep; software should switch it off first
// R2: power-on reset loads comparator two control with its reset value, pins analog
// R3: reference offers thirty-two levels, sixteen per range, via range bit and level code
// R4: range bit one selects tap level/24 of supply
// R5: range bit zero selects tap quarter supply plus level/32 of supply
// R6: disabled reference with code zero and range set drives reference to ground
// R7: bit seven powers the reference on when set, off when clear
// R8: bit six overrides reference pin direction and drives reference onto pin
// R9: bit five chooses low range when one, high range when zero
// R10: bit four unimplemented reads zero; bits three to zero hold level code
// R11: reference control resets to zero; all bits writable except bit four
// R12: programmable reference goes only to a comparator two input
// R13: each comparator result is a read-only bit seven of its control register
// R14: wake flag sets when wake enabled, latched by read, sleeping, and output changes
// R15: wake flag clears by software write or by device reset
// R16: comparator two negative select zero picks the reference, one picks the pin
// R17: writes update on the write's ending edge; reads leave contents unchanged
module ccr_regs
   import ccr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // axi4-lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog comparator results, asynchronous
   input wire logic comp_one_result_in,
   input wire logic comp_two_result_in,
   // control to the analog macro
   output logic comp_one_on,
   output logic comp_two_on,
   output logic comp_two_neg_ref,
   output logic reference_power_on,
   output logic reference_pin_drive,
   output logic reference_ground,
   output logic reference_to_comp_two,
   output logic [4:0] reference_tap,
   output logic [7:0] comp_one_ctrl,
   output logic [7:0] comp_two_ctrl,
   // wake and interrupt
   output logic wake_request,
   output logic irq
);

   // reset release through two flops
   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   logic rst_q_n;
   assign rst_q_n = rst_s2_q;

   // comparator result synchronisers
   logic [1:0] res_s1_q;
   logic [1:0] res_s2_q;
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         res_s1_q <= 2'h3; // start at the result bits' reset value, no false change
         res_s2_q <= 2'h3;
      end
      else
      begin
         res_s1_q <= {comp_two_result_in, comp_one_result_in};
         res_s2_q <= res_s1_q;
      end
   end

   // registers
   logic [7:0] cmp1_q;
   logic [7:0] cmp2_q;
   logic [7:0] vref_q;
   logic wake_flag_q;
   logic sleep_q;
   logic [1:0] latched_q;
   logic armed_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic [1:0] res_prev_q;

   // write channel: address and data taken in either order
   logic aw_held_q;
   logic w_held_q;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic [11:0] wr_addr;
   logic [7:0] wr_byte;
   logic wr_lane;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_addr = aw_addr_q;
   assign wr_byte = w_data_q[7:0];
   assign wr_lane = w_strb_q[0];

   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held_q && !s_axi_awready;
         s_axi_wready <= !w_held_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
      end
   end

   // write response, one cycle after both halves are in
   logic wr_known;
   always_comb
   begin
      unique case (wr_addr)
         `CCR_OFS_STATUS, `CCR_OFS_CMP1, `CCR_OFS_CMP2, `CCR_OFS_VREF,
         `CCR_OFS_IRQ_STAT, `CCR_OFS_IRQ_MASK, `CCR_OFS_SLEEP: wr_known = 1'b1;
         default: wr_known = 1'b0;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CCR_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   logic wr_en;
   assign wr_en = wr_fire && wr_lane;

   // comparator control: result bit read-only, rest writable
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         cmp1_q <= `CCR_RST_CMP;
         cmp2_q <= `CCR_RST_CMP; // R2
      end
      else
      begin
         cmp1_q[`CCR_BIT_RESULT] <= res_s2_q[0]; // R13
         cmp2_q[`CCR_BIT_RESULT] <= res_s2_q[1]; // R13
         if (wr_en && wr_addr == `CCR_OFS_CMP1)
            cmp1_q[6:0] <= wr_byte[6:0]; // R17
         if (wr_en && wr_addr == `CCR_OFS_CMP2)
            cmp2_q[6:0] <= wr_byte[6:0]; // R17
      end
   end

   // reference control: bit four never stored
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
         vref_q <= `CCR_RST_VREF; // R11
      else if (wr_en && wr_addr == `CCR_OFS_VREF)
         vref_q <= wr_byte & `CCR_WMASK_VREF; // R10 R11 R17
   end

   // sleep state, set by the core through its own register
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
         sleep_q <= 1'b0;
      else if (wr_en && wr_addr == `CCR_OFS_SLEEP)
         sleep_q <= wr_byte[0];
   end

   // read side
   logic rd_fire;
   logic rd_cmp;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_cmp = rd_fire && (s_axi_araddr == `CCR_OFS_CMP1 || s_axi_araddr == `CCR_OFS_CMP2);

   // wake detection: a control read latches the results and arms the detector
   logic [1:0] wake_en;
   logic [1:0] changed;
   logic wake_set;
   assign wake_en = {~cmp2_q[`CCR_BIT_WAKE_DIS], ~cmp1_q[`CCR_BIT_WAKE_DIS]};
   assign changed = res_s2_q ^ latched_q;
   assign wake_set = armed_q && sleep_q && |(changed & wake_en); // R14
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         latched_q <= 2'h0;
         armed_q <= 1'b0;
      end
      else if (rd_cmp)
      begin
         latched_q <= res_s2_q; // R14
         armed_q <= 1'b1;
      end
   end

   // wake flag: set wins over a software clear
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
         wake_flag_q <= 1'b0; // R15
      else if (wake_set)
         wake_flag_q <= 1'b1; // R14
      else if (wr_en && wr_addr == `CCR_OFS_STATUS && !wr_byte[`CCR_BIT_WAKE_FLAG])
         wake_flag_q <= 1'b0; // R15
   end

   // interrupt status: wake, comparator one and two changes, write one to clear
   logic [2:0] irq_ev;
   assign irq_ev = {res_s2_q[1] ^ res_prev_q[1], res_s2_q[0] ^ res_prev_q[0], wake_set};
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         res_prev_q <= 2'h3; // same as the synchroniser reset, no event after reset
         irq_stat_q <= 3'h0;
         irq_mask_q <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         res_prev_q <= res_s2_q;
         if (wr_en && wr_addr == `CCR_OFS_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~wr_byte[2:0]) | irq_ev;
         else
            irq_stat_q <= irq_stat_q | irq_ev;
         if (wr_en && wr_addr == `CCR_OFS_IRQ_MASK)
            irq_mask_q <= wr_byte[2:0];
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read data mux
   logic [7:0] rd_byte;
   logic rd_known;
   always_comb
   begin
      rd_known = 1'b1;
      unique case (s_axi_araddr)
         `CCR_OFS_STATUS: rd_byte = {1'b0, wake_flag_q, 6'h00};
         `CCR_OFS_CMP1: rd_byte = cmp1_q; // R13
         `CCR_OFS_CMP2: rd_byte = cmp2_q; // R13
         `CCR_OFS_VREF: rd_byte = vref_q; // R10
         `CCR_OFS_IRQ_STAT: rd_byte = {5'h00, irq_stat_q};
         `CCR_OFS_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
         `CCR_OFS_SLEEP: rd_byte = {7'h00, sleep_q};
         default:
         begin
            rd_byte = 8'h00;
            rd_known = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CCR_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (rd_fire)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte}; // R17
            s_axi_rresp <= rd_known ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // analog controls, registered
   ccr_tap_type tap;
   assign tap = '{low_range: vref_q[`CCR_BIT_REF_RANGE], level: vref_q[3:0]}; // R3 R9
   always_ff @(posedge clk_sys or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         comp_one_on <= 1'b1;
         comp_two_on <= 1'b1;
         comp_two_neg_ref <= 1'b0;
         reference_power_on <= 1'b0;
         reference_pin_drive <= 1'b0;
         reference_ground <= 1'b0;
         reference_to_comp_two <= 1'b0;
         reference_tap <= 5'h00;
         comp_one_ctrl <= `CCR_RST_CMP;
         comp_two_ctrl <= `CCR_RST_CMP;
         wake_request <= 1'b0;
      end
      else
      begin
         comp_one_on <= cmp1_q[`CCR_BIT_ON]; // R1
         comp_two_on <= cmp2_q[`CCR_BIT_ON]; // R1
         comp_two_neg_ref <= ~cmp2_q[`CCR_BIT_NEG_SEL]; // R16
         reference_to_comp_two <= cmp2_q[`CCR_BIT_ON] && !cmp2_q[`CCR_BIT_NEG_SEL]; // R12 R16
         reference_power_on <= vref_q[`CCR_BIT_REF_POWER]; // R7
         reference_pin_drive <= vref_q[`CCR_BIT_REF_PIN]; // R8
         // low range: level/24; high range: quarter plus level/32
         reference_tap <= {tap.low_range, tap.level}; // R4 R5
         reference_ground <= !vref_q[`CCR_BIT_REF_POWER] && tap.low_range && tap.level == 4'h0; // R6
         comp_one_ctrl <= cmp1_q;
         comp_two_ctrl <= cmp2_q;
         wake_request <= wake_flag_q;
      end
   end

   // checks
   a_vref_bit4_zero: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      vref_q[`CCR_BIT_REF_UNUSED] == 1'b0) else $error("reference bit four set"); // R10
   a_ground_tap: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      (vref_q == 8'h20) |=> reference_ground) else $error("ground tap missing"); // R6
   a_power_follow: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      ##1 reference_power_on == $past(vref_q[7])) else $error("power bit not followed"); // R7
   a_pin_follow: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      ##1 reference_pin_drive == $past(vref_q[6])) else $error("pin drive not followed"); // R8
   a_range_tap: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      ##1 reference_tap[4] == $past(vref_q[5])) else $error("range not followed"); // R9
   a_wake_sets: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      wake_set |=> wake_flag_q) else $error("wake flag not set"); // R14
   a_wake_needs_sleep: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      $rose(wake_flag_q) |-> $past(sleep_q)) else $error("wake outside sleep"); // R14
   a_vref_write: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      (wr_en && wr_addr == `CCR_OFS_VREF) |=> vref_q == ($past(wr_byte) & 8'hEF)) else $error("vref write"); // R17
   a_result_ro: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      ##2 cmp1_q[7] == $past(res_s2_q[0], 1)) else $error("result not tracked"); // R13
   a_refsel_c2: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
      reference_to_comp_two |-> $past(!cmp2_q[2])) else $error("ref routed wrongly"); // R12 R16

endmodule : ccr_regs

// ### test/comparator_reference_control_tb_top.sv
`timescale 1ns/1ps
`include "ccr_map.svh"
module comparator_reference_control_tb_top;
   import ccr_pkg::*;
   // clock, reset and bus stimulus
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic comp_one_result_in = 1'b1;
   logic comp_two_result_in = 1'b1;
   logic comp_one_on, comp_two_on, comp_two_neg_ref, reference_power_on, reference_pin_drive;
   logic reference_ground, reference_to_comp_two, wake_request, irq;
   logic [4:0] reference_tap;
   logic [7:0] comp_one_ctrl, comp_two_ctrl;
   int bad_count = 0;
   int cmp_count = 0;
   logic [1:0] resp;
   logic [31:0] rdat;
   logic [7:0] vals [7] = '{8'h00, 8'h0F, 8'h20, 8'h2F, 8'h25, 8'hC3, 8'hFF};

   // 4 ns clock
   always #2 clk_sys = ~clk_sys;

   ccr_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .comp_one_result_in(comp_one_result_in),
      .comp_two_result_in(comp_two_result_in), .comp_one_on(comp_one_on), .comp_two_on(comp_two_on),
      .comp_two_neg_ref(comp_two_neg_ref), .reference_power_on(reference_power_on),
      .reference_pin_drive(reference_pin_drive), .reference_ground(reference_ground),
      .reference_to_comp_two(reference_to_comp_two), .reference_tap(reference_tap),
      .comp_one_ctrl(comp_one_ctrl), .comp_two_ctrl(comp_two_ctrl), .wake_request(wake_request),
      .irq(irq));

   // verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   // compare one value, count and report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // write: address and data offered together, each released when taken
   task automatic bus_write(input logic [11:0] addr, input logic [7:0] data, input logic [3:0] strb,
      output logic [1:0] rsp);
      logic aw_open;
      logic w_open;
      logic aw_hit;
      logic w_hit;
      @(posedge clk_sys);
      s_axi_awaddr <= addr;
      s_axi_wdata <= {24'h000000, data};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_open = 1'b1;
      w_open = 1'b1;
      while (aw_open || w_open)
      begin
         @(negedge clk_sys);
         aw_hit = aw_open && (s_axi_awready === 1'b1);
         w_hit = w_open && (s_axi_wready === 1'b1);
         @(posedge clk_sys);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
         aw_open = aw_open && !aw_hit;
         w_open = w_open && !w_hit;
      end
      while (s_axi_bvalid !== 1'b1) @(negedge clk_sys);
      rsp = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
      // registered outputs launched at this edge settle before any check
      @(negedge clk_sys);
   endtask : bus_write

   // read: address held until taken, rready held until rvalid
   task automatic bus_read(input logic [11:0] addr, output logic [31:0] dat, output logic [1:0] rsp);
      @(posedge clk_sys);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(negedge clk_sys);
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask : bus_read

   // full-strobe write expecting an okay response
   task automatic wr(input logic [11:0] addr, input logic [7:0] data);
      bus_write(addr, data, 4'hF, resp);
      chk("write response", {30'h0, CCR_RESP_OKAY}, {30'h0, resp});
   endtask : wr

   // read, mask and compare
   task automatic rd(input string what, input logic [11:0] addr, input logic [7:0] msk, input logic [7:0] exp);
      bus_read(addr, rdat, resp);
      chk("read response", {30'h0, CCR_RESP_OKAY}, {30'h0, resp});
      chk(what, {24'h000000, exp & msk}, rdat & {24'h000000, msk});
   endtask : rd

   // reset sequence held for 12 cycles
   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
   endtask : do_reset

   // watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      stop_test();
   end

   // main sequence
   initial
   begin
      do_reset();
      rd("comp one ctrl", `CCR_OFS_CMP1, 8'hFF, `CCR_RST_CMP);
      rd("comp two ctrl", `CCR_OFS_CMP2, 8'hFF, `CCR_RST_CMP);
      rd("ref ctrl", `CCR_OFS_VREF, 8'hFF, `CCR_RST_VREF);
      rd("wake flag", `CCR_OFS_STATUS, 8'h40, 8'h00);
      chk("comp two on", 1, comp_two_on);
      chk("ref power", 0, reference_power_on);
      chk("comp one copy", `CCR_RST_CMP, comp_one_ctrl);
      chk("comp two copy", `CCR_RST_CMP, comp_two_ctrl);
      $display("test reset values done");

      foreach (vals[i])
      begin
         wr(`CCR_OFS_VREF, vals[i]);
         rd("ref ctrl", `CCR_OFS_VREF, 8'hFF, vals[i] & `CCR_WMASK_VREF);
         chk("ref tap", {vals[i][5], vals[i][3:0]}, reference_tap);
         chk("ref power", vals[i][7], reference_power_on);
         chk("ref pin", vals[i][6], reference_pin_drive);
         chk("ref ground", !vals[i][7] && vals[i][5] && vals[i][3:0] == 4'h0, reference_ground);
      end
      bus_write(`CCR_OFS_VREF, 8'h55, 4'hE, resp);
      rd("ref ctrl no strobe", `CCR_OFS_VREF, 8'hFF, 8'hEF);
      $display("test reference control done");

      wr(`CCR_OFS_CMP2, 8'h00);
      rd("comp two ctrl", `CCR_OFS_CMP2, 8'hFF, 8'h80);
      chk("comp two on", 0, comp_two_on);
      wr(`CCR_OFS_CMP2, 8'h08);
      chk("ref to comp two", 1, reference_to_comp_two);
      chk("neg ref", 1, comp_two_neg_ref);
      wr(`CCR_OFS_CMP2, 8'h0C);
      chk("ref to comp two", 0, reference_to_comp_two);
      chk("neg ref", 0, comp_two_neg_ref);
      @(posedge clk_sys);
      comp_two_result_in <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd("comp two result", `CCR_OFS_CMP2, 8'hFF, 8'h0C);
      chk("comp two copy", 8'h0C, comp_two_ctrl);
      rd("irq status", `CCR_OFS_IRQ_STAT, 8'h06, 8'h04);
      $display("test comparator two done");

      bus_read(12'h100, rdat, resp);
      chk("unmapped read resp", {30'h0, CCR_RESP_SLVERR}, {30'h0, resp});
      chk("unmapped read data", 0, rdat);
      bus_write(12'h100, 8'hFF, 4'hF, resp);
      chk("unmapped write resp", {30'h0, CCR_RESP_SLVERR}, {30'h0, resp});
      $display("test unmapped done");

      // wake on comparator one change while asleep
      wr(`CCR_OFS_IRQ_STAT, 8'h07);
      wr(`CCR_OFS_IRQ_MASK, 8'h01);
      wr(`CCR_OFS_CMP1, 8'h08);
      wr(`CCR_OFS_SLEEP, 8'h01);
      rd("comp one ctrl", `CCR_OFS_CMP1, 8'hFF, 8'h88);
      comp_one_result_in <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd("wake flag", `CCR_OFS_STATUS, 8'h40, 8'h40);
      chk("comp one on", 1, comp_one_on);
      chk("wake request", 1, wake_request);
      chk("irq raised", 1, irq);
      wr(`CCR_OFS_IRQ_MASK, 8'h00);
      chk("irq masked", 0, irq);
      wr(`CCR_OFS_SLEEP, 8'h00);
      wr(`CCR_OFS_STATUS, 8'h00);
      rd("wake flag", `CCR_OFS_STATUS, 8'h40, 8'h00);
      rd("irq status", `CCR_OFS_IRQ_STAT, 8'h01, 8'h01);
      wr(`CCR_OFS_IRQ_STAT, 8'h07);
      wr(`CCR_OFS_IRQ_MASK, 8'h01);
      rd("irq status", `CCR_OFS_IRQ_STAT, 8'h01, 8'h00);
      chk("irq cleared", 0, irq);
      $display("test wake set done");

      // wake disabled: change while asleep leaves the flag clear
      wr(`CCR_OFS_CMP1, 8'h09);
      wr(`CCR_OFS_SLEEP, 8'h01);
      rd("comp one ctrl", `CCR_OFS_CMP1, 8'hFF, 8'h09);
      comp_one_result_in <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd("wake flag", `CCR_OFS_STATUS, 8'h40, 8'h00);
      chk("wake request", 0, wake_request);
      $display("test wake disabled done");

      // second reset in mid-run restores defaults
      wr(`CCR_OFS_VREF, 8'hA5);
      do_reset();
      rd("ref ctrl", `CCR_OFS_VREF, 8'hFF, `CCR_RST_VREF);
      rd("comp one ctrl", `CCR_OFS_CMP1, 8'hFF, `CCR_RST_CMP);
      rd("comp two ctrl", `CCR_OFS_CMP2, 8'h7F, `CCR_RST_CMP);
      $display("test second reset done");
      stop_test();
   end
endmodule : comparator_reference_control_tb_top
